// *** fo_gpio_pkg.sv ***
// Package of constants for the fail-output / alternate pin block.
// Assumes a 10 MHz system clock; all timing counts derive from it.
package fo_gpio_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  // Register indices on the plain register port.
  localparam logic [3:0] ADDR_PIN_CFG = 4'h0;
  localparam logic [3:0] ADDR_FO_CTRL = 4'h1;
  localparam logic [3:0] ADDR_WAKE_STAT = 4'h2;
  localparam logic [3:0] ADDR_LEVEL_STAT = 4'h3;
  localparam logic [3:0] ADDR_MODE_STAT = 4'h4;
  // Pin configuration encodings (3 bits per pin).
  typedef enum logic [2:0] {
    CFG_FAIL_OUT = 3'h0,
    CFG_OFF = 3'h1,
    CFG_WAKE_IN = 3'h2,
    CFG_LOW_SIDE = 3'h3,
    CFG_HIGH_SIDE = 3'h4
  } pin_cfg_t;
  localparam logic [5:0] PIN_CFG_RESET = 6'h00;
  // Operating modes of the device.
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_STOP = 3'h1,
    MODE_SLEEP = 3'h2,
    MODE_RESTART = 3'h3,
    MODE_FAIL_SAFE = 3'h4
  } sys_mode_t;
  // Control register fields.
  localparam int FO_FORCE_BIT = 0;
  localparam int DUTY_LSB = 1;
  localparam logic [1:0] DUTY_RESET = 2'h0; // 20 percent
  // Waveform timing.
  localparam int unsigned IND_PERIOD_MHZ = 1250; // 1.25 Hz in mHz
  localparam int unsigned IND_PERIOD_CYC = int'(64'(CLK_HZ) * 1000 / IND_PERIOD_MHZ);
  localparam int unsigned IND_HIGH_PCT = 50;
  localparam int unsigned PULSE_HZ = 100;
  localparam int unsigned PULSE_PERIOD_CYC = CLK_HZ / PULSE_HZ;
  // Pulsed duty in per-mille: 20, 10, 5, 2.5 percent.
  localparam int unsigned DUTY_PM0 = 200;
  localparam int unsigned DUTY_PM1 = 100;
  localparam int unsigned DUTY_PM2 = 50;
  localparam int unsigned DUTY_PM3 = 25;
  localparam int unsigned STRAP_FILT_US = 64;
  localparam int unsigned STRAP_FILT_CYC = (STRAP_FILT_US * (CLK_HZ / 1000000));
  localparam int unsigned WAKE_FILT_US = 64;
  localparam int unsigned WAKE_FILT_CYC = (WAKE_FILT_US * (CLK_HZ / 1000000));
endpackage

// *** level_filter.sv ***
// Level filter: the output follows the input once it has been stable for FILT_CYC clocks.
// Assumes the input is already synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module level_filter #(
  parameter int unsigned FILT_CYC = 640,
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic sys_clk, // System clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic level_in, // Raw level
  output logic level_out // Filtered level
);
  localparam int W = $clog2(FILT_CYC + 1);
  if (FILT_CYC < 1)
  begin : g_bad_filt
    $error("FILT_CYC must be at least 1");
  end
  logic [W-1:0] cnt_q, cnt_d;
  logic lvl_q, lvl_d;
  always_comb
  begin
    cnt_d = '0;
    lvl_d = lvl_q;
    if (level_in != lvl_q)
    begin
      if (cnt_q == W'(FILT_CYC - 1))
        lvl_d = level_in;
      else
        cnt_d = cnt_q + W'(1);
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cnt_q <= '0;
      lvl_q <= RESET_LEVEL;
    end
    else
    begin
      cnt_q <= cnt_d;
      lvl_q <= lvl_d;
    end
  end
  assign level_out = lvl_q;
endmodule // level_filter
`default_nettype wire

// *** fo_gpio.sv ***
// Fail outputs with alternate general-purpose pin functions.
// Assumes the mode and failure inputs come from the device's state logic, synchronous to sys_clk.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RL1] Pins start as fail outputs; software reconfigures.
// [RL2] Wake input filtered like dedicated wake pins.
// [RL3] Wake events latched in wake status register.
// [RL4] Pin levels shown in Normal and Stop.
// [RL5] Pin b level shares the strap bit.
// [RL6] Switches: no diagnostics beyond level feedback.
// [RL7] Configuration writable only in Normal mode.
// [RL8] Switch and fail settings held in Stop/Sleep.
// [RL9] Wake input works in Stop, Sleep, Restart.
// [RL10] Wake disabled in Fail-Safe, resumes afterwards.
// [RL11] Switches off in Restart and Fail-Safe.
// [RL12] Switches resume after Restart, register unchanged.
// [RL13] Fail outputs active on failure-forced modes.
// [RL14] Activated fail output persists into Normal.
// [RL15] Indicator output: 1.25 Hz, 50 percent.
// [RL16] Pulsed output: 100 Hz, selectable duty.
// [RL17] Strap input filtered for 64 us.
// [RL18] Outside circuit holds strap pin high.
// [RL19] Duty choices 20, 10, 5, 2.5 percent.
// [RL20] Three fail outputs activate together.
// [RL21] Force bit activates outputs for test.
// [RL22] Waveforms restart at activation start.
module fo_gpio
  import fo_gpio_pkg::*;
#(
  parameter int unsigned IND_CYC = IND_PERIOD_CYC,
  parameter int unsigned PULSE_CYC = PULSE_PERIOD_CYC,
  parameter int unsigned STRAP_CYC = STRAP_FILT_CYC,
  parameter int unsigned WAKE_CYC = WAKE_FILT_CYC
) (
  input wire logic sys_clk, // System clock, 10 MHz
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic [3:0] reg_addr, // Register index
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, valid the cycle after reg_rd
  input wire logic [2:0] sys_mode, // Present device mode
  input wire logic failure_act, // Failure has forced Restart or Fail-Safe
  input wire logic failure_clr, // Failure flag cleared, no failure present
  input wire logic alt_pin_a_in, // Level at indicator pin
  input wire logic pulsed_fail_out_strap_pin_in, // Level at pulsed/strap pin
  output logic static_fail_out_oe, // Drives first fail pin low
  output logic [1:0] pin_out, // Output value per alternate pin
  output logic [1:0] pin_oe, // Output enable per alternate pin
  output logic [1:0] wake_pulse, // Wake event pulse per pin
  output logic strap_level // Filtered strap level
);
  // Shorter periods leave no room for the 2.5 percent pulse or for the half-period split.
  if (IND_CYC < 2)
  begin : g_bad_ind
    $error("IND_CYC must be at least 2");
  end
  if (PULSE_CYC < 40)
  begin : g_bad_pulse
    $error("PULSE_CYC must be at least 40");
  end
  if (STRAP_CYC < 1 || WAKE_CYC < 1)
  begin : g_bad_filt
    $error("Filter times must be at least one cycle");
  end
  localparam int IW = $clog2(IND_CYC);
  localparam int PW = $clog2(PULSE_CYC);
  // Mode codes above Fail-Safe are never produced by the mode logic; they would act
  // like a running mode here, so the mode logic must keep them out.
  sys_mode_t mode;
  assign mode = sys_mode_t'(sys_mode);
  logic [5:0] cfg_q, cfg_d;
  logic force_q, force_d;
  logic [1:0] duty_q, duty_d;
  logic fail_q, fail_d;
  logic [1:0] wake_stat_q, wake_stat_d;
  logic [1:0] lvl_stat_q, lvl_stat_d;
  logic [7:0] rdata_q, rdata_d;
  logic [IW-1:0] ind_cnt_q, ind_cnt_d;
  logic [PW-1:0] pul_cnt_q, pul_cnt_d;
  logic [1:0] out_q, out_d, oe_q, oe_d, wk_q, wk_d, filt_prev_q;
  logic static_q, static_d;
  logic strap_d;
  logic [1:0] filt;
  logic [1:0] raw_in;
  logic fo_active, wake_ok, sw_ok;
  logic [PW-1:0] duty_cyc;
  pin_cfg_t cfg_a, cfg_b;
  assign raw_in = {pulsed_fail_out_strap_pin_in, alt_pin_a_in};
  assign cfg_a = pin_cfg_t'(cfg_q[2:0]);
  assign cfg_b = pin_cfg_t'(cfg_q[5:3]);
  // The force bit and the failure latch act alike on all three outputs.
  assign fo_active = fail_q | force_q; // RL20 RL21
  // Wake filters; the filter on pin b also serves the strap input.
  level_filter #(.FILT_CYC(WAKE_CYC), .RESET_LEVEL(1'b1)) u_filt_a ( // RL2
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .level_in(raw_in[0]),
    .level_out(filt[0])
  );
  level_filter #(.FILT_CYC(STRAP_CYC), .RESET_LEVEL(1'b1)) u_filt_b ( // RL17
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .level_in(raw_in[1]),
    .level_out(filt[1])
  );
  // Duty counts round down; the shortest permitted period still leaves one cycle at
  // the 2.5 percent setting.
  always_comb
  begin
    case (duty_q) // RL19
      2'h0: duty_cyc = PW'(PULSE_CYC * DUTY_PM0 / 1000);
      2'h1: duty_cyc = PW'(PULSE_CYC * DUTY_PM1 / 1000);
      2'h2: duty_cyc = PW'(PULSE_CYC * DUTY_PM2 / 1000);
      default: duty_cyc = PW'(PULSE_CYC * DUTY_PM3 / 1000);
    endcase
  end
  // Wake detection stays live through Restart so that a wake there is not lost; only
  // Fail-Safe silences it. Switches drop in both failure modes and come back by
  // themselves, because the configuration register is never touched on the way.
  always_comb
  begin
    wake_ok = (mode != MODE_FAIL_SAFE); // RL9 RL10
    sw_ok = (mode != MODE_RESTART) && (mode != MODE_FAIL_SAFE); // RL11 RL12
  end
  // Control and status registers.
  always_comb
  begin
    cfg_d = cfg_q;
    force_d = force_q;
    duty_d = duty_q;
    fail_d = fail_q;
    wake_stat_d = wake_stat_q;
    lvl_stat_d = lvl_stat_q;
    rdata_d = 8'h00;
    // Writes outside Normal are dropped rather than deferred, so Stop and Sleep keep
    // the last Normal setting exactly.
    if (reg_wr && reg_addr == ADDR_PIN_CFG && mode == MODE_NORMAL)
      cfg_d = reg_wdata[5:0]; // RL1 RL7 RL8
    if (reg_wr && reg_addr == ADDR_FO_CTRL)
    begin
      force_d = reg_wdata[FO_FORCE_BIT]; // RL21
      duty_d = reg_wdata[DUTY_LSB +: 2]; // RL16
    end
    // Failure latch; it survives Restart and the return to Normal.
    if (failure_clr)
      fail_d = 1'b0;
    if (failure_act)
      fail_d = 1'b1; // RL13 RL14
    if (reg_wr && reg_addr == ADDR_WAKE_STAT)
      wake_stat_d = wake_stat_q & ~reg_wdata[1:0];
    wake_stat_d = wake_stat_d | wk_d; // RL3
    // Outside Normal and Stop the level status keeps the last value it showed, which
    // is what software finds when it reads it on return.
    if (mode == MODE_NORMAL || mode == MODE_STOP)
      lvl_stat_d = filt; // RL4 RL5
    // Read data are zero outside the cycle after a read, so no stale value is seen.
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_PIN_CFG: rdata_d = {2'h0, cfg_q};
        ADDR_FO_CTRL: rdata_d = {5'h00, duty_q, force_q};
        ADDR_WAKE_STAT: rdata_d = {6'h00, wake_stat_q};
        ADDR_LEVEL_STAT: rdata_d = {6'h00, lvl_stat_q}; // RL6
        ADDR_MODE_STAT: rdata_d = {4'h0, fo_active, sys_mode};
        default: rdata_d = 8'h00;
      endcase
    end
  end
  // Waveform counters held at zero while inactive so each activation starts a fresh period.
  always_comb
  begin
    ind_cnt_d = '0;
    pul_cnt_d = '0;
    if (fo_active)
    begin
      ind_cnt_d = (ind_cnt_q == IW'(IND_CYC - 1)) ? '0 : ind_cnt_q + IW'(1); // RL22
      pul_cnt_d = (pul_cnt_q == PW'(PULSE_CYC - 1)) ? '0 : pul_cnt_q + PW'(1); // RL22
    end
  end
  // Pin drivers. Fail outputs are open drain, active low: enable means pulled low.
  always_comb
  begin
    logic [2:0] c;
    logic ind_on, pul_on;
    c = 3'h0;
    ind_on = ind_cnt_q < IW'(IND_CYC * IND_HIGH_PCT / 100); // RL15
    pul_on = pul_cnt_q < duty_cyc; // RL16
    static_d = fo_active; // RL20
    out_d = 2'b00;
    oe_d = 2'b00;
    wk_d = 2'b00;
    for (int i = 0; i < 2; i++)
    begin
      c = (i == 0) ? cfg_a : cfg_b;
      case (pin_cfg_t'(c))
        CFG_FAIL_OUT:
        begin
          oe_d[i] = fo_active & ((i == 0) ? ind_on : pul_on);
          out_d[i] = 1'b0;
        end
        CFG_LOW_SIDE:
        begin
          oe_d[i] = sw_ok; // RL11
          out_d[i] = 1'b0;
        end
        CFG_HIGH_SIDE:
        begin
          oe_d[i] = sw_ok; // RL11
          out_d[i] = 1'b1;
        end
        // Either filtered edge is a wake event; the filter has already removed glitches.
        CFG_WAKE_IN:
          wk_d[i] = wake_ok & (filt[i] != filt_prev_q[i]); // RL2 RL9 RL10
        default:
        begin
          oe_d[i] = 1'b0;
          out_d[i] = 1'b0;
        end
      endcase
    end
  end
  // Control and status registers.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cfg_q <= PIN_CFG_RESET;
      force_q <= 1'b0;
      duty_q <= DUTY_RESET;
      fail_q <= 1'b0;
      wake_stat_q <= 2'h0;
      lvl_stat_q <= 2'h3;
      rdata_q <= 8'h00;
    end
    else
    begin
      cfg_q <= cfg_d;
      force_q <= force_d;
      duty_q <= duty_d;
      fail_q <= fail_d;
      wake_stat_q <= wake_stat_d;
      lvl_stat_q <= lvl_stat_d;
      rdata_q <= rdata_d;
    end
  end
  // Waveform counters.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ind_cnt_q <= '0;
      pul_cnt_q <= '0;
    end
    else
    begin
      ind_cnt_q <= ind_cnt_d;
      pul_cnt_q <= pul_cnt_d;
    end
  end
  // Pin drivers and the edge history of the filtered levels.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      out_q <= 2'h0;
      oe_q <= 2'h0;
      wk_q <= 2'h0;
      filt_prev_q <= 2'h3;
      static_q <= 1'b0;
    end
    else
    begin
      out_q <= out_d;
      oe_q <= oe_d;
      wk_q <= wk_d;
      filt_prev_q <= filt;
      static_q <= static_d;
    end
  end
  // The strap level is followed in every mode and configuration; the decision it feeds
  // must not depend on how software has set the pin up.
  always_comb
  begin
    strap_d = filt[1]; // RL17
  end
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      strap_level <= 1'b1;
    else
      strap_level <= strap_d;
  end
  assign reg_rdata = rdata_q;
  assign static_fail_out_oe = static_q;
  assign pin_out = out_q;
  assign pin_oe = oe_q;
  assign wake_pulse = wk_q;
endmodule // fo_gpio
`default_nettype wire

// *** fo_gpio_checker.sv ***
// Concurrent checks on the fail-output / alternate pin block, bound to fo_gpio.
// Sees only the top ports and tracks the pin configuration from register writes.
`timescale 1ns/1ps
`default_nettype none
module fo_gpio_checker
  import fo_gpio_pkg::*;
#(
  parameter int unsigned IND_CYC = IND_PERIOD_CYC
) (
  input wire logic sys_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic [3:0] reg_addr, // Register index
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic [2:0] sys_mode, // Device mode
  input wire logic failure_act, // Failure seen
  input wire logic failure_clr, // Failure cleared
  input wire logic static_fail_out_oe, // First fail pin
  input wire logic [1:0] pin_oe, // Pin enables
  input wire logic [1:0] wake_pulse // Wake pulses
);
  logic [5:0] cfg_q, cfg_d;
  logic [31:0] hi_q, hi_d;
  wire sw_a = cfg_q[2:0] == CFG_LOW_SIDE || cfg_q[2:0] == CFG_HIGH_SIDE;
  // Settings only change in Normal mode, so the copy follows that condition.
  always_comb
  begin
    cfg_d = cfg_q;
    if (reg_wr && reg_addr == ADDR_PIN_CFG && sys_mode == MODE_NORMAL) cfg_d = reg_wdata[5:0];
    hi_d = pin_oe[0] ? hi_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge sys_clk)
  begin
    cfg_q <= sys_rst ? PIN_CFG_RESET : cfg_d;
    hi_q <= sys_rst ? 32'h0 : hi_d;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  switch_off_a:
    assert property ((sw_a && sys_mode >= MODE_RESTART)[*3] |-> !pin_oe[0]) else $error("switch on");
  switch_held_a:
    assert property ((sw_a && sys_mode < MODE_RESTART)[*3] |-> pin_oe[0]) else $error("switch off");
  wake_no_drive_a:
    assert property ((cfg_q[5:3] == CFG_WAKE_IN)[*3] |-> !pin_oe[1]) else $error("wake pin driven");
  wake_blocked_a:
    assert property ((sys_mode == MODE_FAIL_SAFE)[*3] |-> wake_pulse == 2'b00) else $error("wake seen");
  fail_start_a:
    assert property ($rose(failure_act) |-> ##[1:3] static_fail_out_oe) else $error("fail late");
  fail_keep_a:
    assert property ((static_fail_out_oe && !failure_clr && !reg_wr)[*3] |=> static_fail_out_oe)
      else $error("fail dropped");
  fail_group_a:
    assert property ($rose(static_fail_out_oe) && cfg_q == 6'h00 |-> pin_oe == 2'b11)
      else $error("fail outputs apart");
  indicator_half_a:
    assert property ($fell(pin_oe[0]) && static_fail_out_oe && cfg_q[2:0] == CFG_FAIL_OUT
      |-> hi_q == IND_CYC / 2) else $error("indicator half period wrong");
  wake_single_a:
    assert property (wake_pulse[1] |=> !wake_pulse[1]) else $error("wake pulse long");
endmodule // fo_gpio_checker
bind fo_gpio fo_gpio_checker #(.IND_CYC(IND_CYC)) checker_u (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .sys_mode(sys_mode), .failure_act(failure_act), .failure_clr(failure_clr),
  .static_fail_out_oe(static_fail_out_oe), .pin_oe(pin_oe), .wake_pulse(wake_pulse)
);
`default_nettype wire

// *** ext_loads.sv ***
// Outside loads and wake sources on the two alternate pins.
// A released pin shows the level that the outside source sets.
`timescale 1ns/1ps
`default_nettype none
module ext_loads (
  input wire logic [1:0] pin_out, // Driven values
  input wire logic [1:0] pin_oe, // Drive enables
  input wire logic [1:0] src_lvl, // Outside source levels
  output logic alt_pin_a_in, // Indicator pin level
  output logic pulsed_fail_out_strap_pin_in // Pulsed/strap pin level
);
  assign alt_pin_a_in = pin_oe[0] ? pin_out[0] : src_lvl[0];
  assign pulsed_fail_out_strap_pin_in = pin_oe[1] ? pin_out[1] : src_lvl[1];
endmodule // ext_loads
`default_nettype wire

// *** fo_gpio_tb.sv ***
// Testbench for fo_gpio: register tasks, mode and failure stimulus, pin sources.
// Assumes shortened timing parameters so waveforms fit a short run.
`timescale 1ns/1ps
`default_nettype none
module fo_gpio_tb;
  import fo_gpio_pkg::*;
  localparam int PC = 400;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] sys_mode = 3'h0;
  logic failure_act = 1'b0;
  logic failure_clr = 1'b0;
  logic [1:0] src_lvl = 2'b11;
  logic [7:0] reg_rdata;
  logic [1:0] pin_out, pin_oe, wake_pulse;
  logic static_fail_out_oe, strap_level, pin_a, pin_b;
  int failures = 0;
  int check_count = 0;
  int n;
  int pm[4] = '{200, 100, 50, 25};
  always #50 sys_clk = ~sys_clk;
  fo_gpio #(.IND_CYC(100), .PULSE_CYC(PC), .STRAP_CYC(4), .WAKE_CYC(4)) dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sys_mode(sys_mode),
    .failure_act(failure_act), .failure_clr(failure_clr), .alt_pin_a_in(pin_a),
    .pulsed_fail_out_strap_pin_in(pin_b), .static_fail_out_oe(static_fail_out_oe),
    .pin_out(pin_out), .pin_oe(pin_oe), .wake_pulse(wake_pulse), .strap_level(strap_level));
  ext_loads load_u (.pin_out(pin_out), .pin_oe(pin_oe), .src_lvl(src_lvl),
    .alt_pin_a_in(pin_a), .pulsed_fail_out_strap_pin_in(pin_b));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic set_mode(input logic [2:0] m);
    @(posedge sys_clk);
    sys_mode <= m;
  endtask
  task automatic set_src(input logic v);
    @(posedge sys_clk);
    src_lvl[1] <= v;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, input string w);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(w, reg_rdata & m, e);
  endtask
  task automatic wait_for(input bit k, input logic v);
    n = 0;
    while ((k ? static_fail_out_oe : wake_pulse[1]) !== v && n < 200)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 200)
    begin
      chk("wait", 8'h00, 8'h01);
      end_sim();
    end
  endtask
  initial
  begin
    tick(4);
    sys_rst <= 1'b0;
    rd(ADDR_PIN_CFG, 8'hff, 8'h00, "cfg reset");
    rd(ADDR_FO_CTRL, 8'hff, 8'h00, "ctrl reset");
    rd(ADDR_LEVEL_STAT, 8'h03, 8'h03, "level reset");
    rd(4'hf, 8'hff, 8'h00, "unmapped");
    set_mode(MODE_STOP);
    wr(ADDR_PIN_CFG, 8'h13);
    rd(ADDR_PIN_CFG, 8'hff, 8'h00, "cfg locked");
    set_mode(MODE_NORMAL);
    wr(ADDR_PIN_CFG, 8'h13);
    set_mode(MODE_SLEEP);
    tick(4);
    #1 chk("switch held", {6'h0, pin_oe[0], pin_out[0]}, 8'h02);
    set_mode(MODE_RESTART);
    tick(4);
    #1 chk("switch off", {7'h0, pin_oe[0]}, 8'h00);
    set_mode(MODE_NORMAL);
    tick(4);
    #1 chk("switch back", {7'h0, pin_oe[0]}, 8'h01);
    rd(ADDR_PIN_CFG, 8'hff, 8'h13, "cfg kept");
    wr(ADDR_PIN_CFG, 8'h14);
    tick(2);
    #1 chk("high side", {6'h0, pin_oe[0], pin_out[0]}, 8'h03);
    tick(4);
    rd(ADDR_LEVEL_STAT, 8'h01, 8'h01, "switch feedback");
    wr(ADDR_PIN_CFG, 8'h11);
    tick(2);
    #1 chk("pin off", {6'h0, pin_oe[0], pin_out[0]}, 8'h00);
    wr(ADDR_PIN_CFG, 8'h12);
    @(posedge sys_clk);
    src_lvl[0] <= 1'b0;
    tick(8);
    rd(ADDR_WAKE_STAT, 8'h03, 8'h01, "wake a");
    wr(ADDR_WAKE_STAT, 8'h01);
    // A one-cycle glitch is shorter than the filter and must leave the strap level alone.
    set_src(1'b0);
    set_src(1'b1);
    tick(8);
    #1 chk("strap glitch", {7'h0, strap_level}, 8'h01);
    set_src(1'b0);
    wait_for(1'b0, 1'b1);
    rd(ADDR_WAKE_STAT, 8'h03, 8'h02, "wake latched");
    rd(ADDR_LEVEL_STAT, 8'h02, 8'h00, "level low");
    chk("strap low", {7'h0, strap_level}, 8'h00);
    wr(ADDR_WAKE_STAT, 8'h02);
    rd(ADDR_WAKE_STAT, 8'h03, 8'h00, "wake cleared");
    set_mode(MODE_SLEEP);
    set_src(1'b1);
    wait_for(1'b0, 1'b1);
    wr(ADDR_WAKE_STAT, 8'h02);
    set_mode(MODE_FAIL_SAFE);
    set_src(1'b0);
    tick(20);
    rd(ADDR_WAKE_STAT, 8'h02, 8'h00, "wake off");
    set_mode(MODE_NORMAL);
    tick(20);
    wr(ADDR_WAKE_STAT, 8'h03);
    set_src(1'b1);
    wait_for(1'b0, 1'b1);
    wr(ADDR_PIN_CFG, 8'h00);
    for (int d = 0; d < 4; d++)
    begin
      wr(ADDR_FO_CTRL, 8'((d << 1) | 1));
      wait_for(1'b1, 1'b1);
      n = 0;
      while (pin_oe[1] === 1'b1 && n < PC)
      begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      chk("pulsed high", 8'(n), 8'(PC * pm[d] / 1000));
      if (n >= PC)
        end_sim();
      wr(ADDR_FO_CTRL, 8'h00);
      wait_for(1'b1, 1'b0);
    end
    @(posedge sys_clk);
    failure_act <= 1'b1;
    sys_mode <= MODE_RESTART;
    @(posedge sys_clk);
    failure_act <= 1'b0;
    tick(60);
    sys_mode <= MODE_NORMAL;
    tick(10);
    #1 chk("fail kept", {7'h0, static_fail_out_oe}, 8'h01);
    rd(ADDR_MODE_STAT, 8'hff, 8'h08, "fail shown");
    @(posedge sys_clk);
    failure_clr <= 1'b1;
    @(posedge sys_clk);
    failure_clr <= 1'b0;
    wait_for(1'b1, 1'b0);
    end_sim();
  end
endmodule // fo_gpio_tb
`default_nettype wire
